// File: logic/drg_glue.sv
// Access and refresh sequencer between a 32-bit host and a DRAM controller.
// Assumes host bus is on clk_sys; controller and strap pins are asynchronous.
`timescale 1ns/100ps
`include "drg_consts.svh"

// What this block does
// - Access starts only with chip select and address strobe both low.
// - Write-enable variant makes four byte write enables from strobe and R/W.
// - Column-strobe variant makes four byte column strobes instead.
// - Column-strobe variant ends row strobe request early; latches keep data.
// - No hidden refresh is ever performed.
// - Low refresh request with no access gives refresh command, mode 0.
// - Refresh request during an access waits until access ends.
// - Access during refresh waits through refresh and precharge, then runs.
// - Zero-wait input sets refresh length; tie refresh to it to shorten.
// - Interleaving: same bank back to back waits for precharge.
// - Column-strobe variant guarantees precharge by ending row strobe early.
// - Without interleaving the previous bank input is free for other use.
// - Row strobe falls when refresh high, stage two low, strobe low.
// - Mode lines show 5 for accesses, 0 for forced refreshes.
// - All memory control signals produced by this block.
// - One wait state in every access by default.
// - Zero-wait low shortens forced refresh by one clock.
// - Spacing gives two precharge periods after accesses and refreshes alike.
module drg_glue (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input drg_pkg::drg_host_t host,
  input wire logic refresh_request_line,
  input wire logic zero_wait_select,
  input wire logic lane_mode_cas,
  input wire logic interleave_en,
  output drg_pkg::drg_dram_t dram_ctl,
  output drg_pkg::drg_lane_t lanes,
  output logic data_ack_n,
  output logic previous_bank_flag
);
  import drg_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  drg_state_t state_reg;
  logic [2:0] cyc_reg;
  logic [1:0] spacing_cnt_reg;
  drg_dram_t dram_reg;
  logic data_ack_n_reg;
  logic prev_bank_reg;
  logic last_ref_reg;
  logic ref_req;
  logic zero_wait_hi;
  logic cas_mode;
  logic ilv;
  logic acc_req;
  logic spacing_delay;
  logic bank_ok;
  logic go_acc;
  logic go_ref;
  logic acc_done;
  logic early_end;
  logic ref_end;
  logic row_release;
  logic [2:0] ref_last;
  logic active;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Controller request and straps come from other clocks
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_meta_reg <= `DRG_PIN_RST;
      pin_sync_reg <= `DRG_PIN_RST;
    end else if (clk_en) begin
      pin_meta_reg <= {interleave_en, lane_mode_cas, zero_wait_select,
        refresh_request_line};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration terms
  // ----------------------------------------------------------------
  // Previous bank only matters with interleaving; otherwise unused
  assign ref_req = !pin_sync_reg[`DRG_PIN_RFREQ];
  assign zero_wait_hi = pin_sync_reg[`DRG_PIN_ZWAIT];
  assign cas_mode = pin_sync_reg[`DRG_PIN_CASV];
  assign ilv = pin_sync_reg[`DRG_PIN_ILV];
  assign acc_req = !host.cs_n && !host.as_n;
  assign spacing_delay = (spacing_cnt_reg != 2'h0);
  assign bank_ok = ilv && !last_ref_reg &&
    (host.bank_bit != prev_bank_reg);
  // Access wins a tie, so a refresh starting in the same cycle never stretches the host cycle
  assign go_acc = (state_reg == ST_IDLE) && acc_req &&
    (!spacing_delay || bank_ok);
  assign go_ref = (state_reg == ST_IDLE) && !acc_req && ref_req &&
    !spacing_delay;
  assign acc_done = ((state_reg == ST_ACC) || (state_reg == ST_TAIL)) &&
    host.as_n;
  assign early_end = (state_reg == ST_ACC) && cas_mode &&
    (cyc_reg == `DRG_EARLY_END_CYC - 3'h1);
  assign ref_last = zero_wait_hi ? `DRG_REF_CYC - 3'h1 :
    `DRG_REF_CYC - 3'h2;
  assign ref_end = (state_reg == ST_REF) && (cyc_reg >= ref_last);
  assign row_release = ((state_reg == ST_ACC) && (acc_done || early_end))
    || ref_end;
  assign active = (state_reg == ST_ACC) || (state_reg == ST_TAIL);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Refresh only starts from idle, so no hidden refresh exists
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cyc_reg <= 3'h0;
    end else if (clk_en) begin
      case (state_reg)
        ST_IDLE: begin
          cyc_reg <= 3'h0;
          if (go_acc) begin
            state_reg <= ST_ACC;
          end else if (go_ref) begin
            state_reg <= ST_REF;
          end
        end
        ST_ACC: begin
          if (cyc_reg != 3'h7) begin
            cyc_reg <= cyc_reg + 3'h1;
          end
          if (acc_done) begin
            state_reg <= ST_IDLE;
          end else if (early_end) begin
            state_reg <= ST_TAIL;
          end
        end
        ST_TAIL: begin
          if (acc_done) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_REF: begin
          cyc_reg <= cyc_reg + 3'h1;
          if (ref_end) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cyc_reg <= 3'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Controller lines
  // ----------------------------------------------------------------
  // Mode lines rest at access mode so an access never waits for them
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dram_reg <= {2'b11, `DRG_MODE_ACCESS};
    end else if (clk_en) begin
      if (go_acc) begin
        dram_reg.row_strobe_request_n <= 1'b0;
      end else if (go_ref) begin
        dram_reg.row_strobe_request_n <= 1'b0;
        dram_reg.refresh_command_n <= 1'b0;
        {dram_reg.mode_select_two, dram_reg.mode_select_one,
          dram_reg.mode_select_zero} <= `DRG_MODE_REFRESH;
      end else if (row_release) begin
        dram_reg.row_strobe_request_n <= 1'b1;
        dram_reg.refresh_command_n <= 1'b1;
        {dram_reg.mode_select_two, dram_reg.mode_select_one,
          dram_reg.mode_select_zero} <= `DRG_MODE_ACCESS;
      end
    end
  end

  // ----------------------------------------------------------------
  // Precharge spacing and bank memory
  // ----------------------------------------------------------------
  // Loaded on every row strobe release, refresh included
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      spacing_cnt_reg <= 2'h0;
    end else if (clk_en) begin
      if (row_release) begin
        spacing_cnt_reg <= `DRG_PRECH_CYC;
      end else if (spacing_delay) begin
        spacing_cnt_reg <= spacing_cnt_reg - 2'h1;
      end
    end
  end

  // Bank of the last access; a refresh hits every bank
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prev_bank_reg <= 1'b0;
      last_ref_reg <= 1'b1;
    end else if (clk_en) begin
      if (go_acc) begin
        prev_bank_reg <= host.bank_bit;
        last_ref_reg <= 1'b0;
      end else if (go_ref) begin
        last_ref_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data acknowledge
  // ----------------------------------------------------------------
  // Held until address strobe ends; never given during refresh
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      data_ack_n_reg <= 1'b1;
    end else if (clk_en) begin
      if (acc_done) begin
        data_ack_n_reg <= 1'b1;
      end else if (go_acc && !zero_wait_hi) begin
        data_ack_n_reg <= 1'b0;
      end else if ((state_reg == ST_ACC) &&
                   (cyc_reg == `DRG_WAIT_CYC - 3'h1)) begin
        data_ack_n_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte lanes and outputs
  // ----------------------------------------------------------------
  drg_lane_gen u_lane (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .host(host),
    .active(active),
    .cas_mode(cas_mode),
    .lanes(lanes)
  );

  assign dram_ctl = dram_reg;
  assign data_ack_n = data_ack_n_reg;
  assign previous_bank_flag = prev_bank_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_start;
    clk_en && go_acc |=> !dram_ctl.row_strobe_request_n &&
      dram_ctl.refresh_command_n && dram_ctl.mode_select_two &&
      !dram_ctl.mode_select_one && dram_ctl.mode_select_zero;
  endproperty
  a_start: assert property (p_start)
    else $error("access start did not drive row strobe in mode 5");

  property p_row_cause;
    $fell(dram_ctl.row_strobe_request_n) && dram_ctl.refresh_command_n
      |-> $past(acc_req) && !($past(spacing_delay) && !$past(bank_ok));
  endproperty
  a_row_cause: assert property (p_row_cause)
    else $error("row strobe fell without a clear access request");

  property p_ref_hold;
    (state_reg == ST_ACC) |=> dram_ctl.refresh_command_n;
  endproperty
  a_ref_hold: assert property (p_ref_hold)
    else $error("refresh command during an access");

  property p_ref_min;
    $fell(dram_ctl.refresh_command_n) |-> (!dram_ctl.refresh_command_n)[*2]
      ##0 (dram_ctl.mode_select_two == 1'b0);
  endproperty
  a_ref_min: assert property (p_ref_min)
    else $error("forced refresh shorter than two clocks");

  property p_ref_short;
    clk_en && (state_reg == ST_REF) && !zero_wait_hi &&
      (cyc_reg >= `DRG_REF_CYC - 3'h2) |=> dram_ctl.refresh_command_n;
  endproperty
  a_ref_short: assert property (p_ref_short)
    else $error("refresh not shortened with zero-wait low");

  property p_one_wait;
    clk_en && go_acc && zero_wait_hi && !host.as_n |=> data_ack_n
      ##1 (!data_ack_n || host.as_n);
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("access did not get exactly one wait state");

  property p_prech;
    clk_en && $rose(dram_ctl.row_strobe_request_n) && (!ilv || last_ref_reg)
      |-> dram_ctl.row_strobe_request_n[*2];
  endproperty
  a_prech: assert property (p_prech)
    else $error("row strobe precharge shorter than two periods");

  property p_early;
    clk_en && early_end && !host.as_n |=>
      dram_ctl.row_strobe_request_n && !data_ack_n;
  endproperty
  a_early: assert property (p_early)
    else $error("column-strobe access did not end row strobe early");

  property p_no_ack_ref;
    !dram_ctl.refresh_command_n |-> data_ack_n;
  endproperty
  a_no_ack_ref: assert property (p_no_ack_ref)
    else $error("data acknowledged during refresh");

  c_access: cover property (go_acc ##[1:8] !data_ack_n);
  c_refresh: cover property ($fell(dram_ctl.refresh_command_n));
  c_wait_ref: cover property ((state_reg == ST_REF) && acc_req
    ##[1:8] go_acc);
  c_early: cover property (early_end);

endmodule

// File: include/drg_consts.svh
// Timing counts, encodings and reset values for the DRAM glue block.
// Assumes a single system clock; all counts are in clk_sys periods.
`ifndef DRG_CONSTS_SVH
`define DRG_CONSTS_SVH

// Cycles before data acknowledge in a normal access (one wait state)
`define DRG_WAIT_CYC 3'h1
// Forced refresh length with zero-wait select high
`define DRG_REF_CYC 3'h3
// Row strobe precharge between accesses, in periods
`define DRG_PRECH_CYC 2'h2
// Row strobe length before early end in column-strobe variant
`define DRG_EARLY_END_CYC 3'h2
// Controller mode lines {two, one, zero}
`define DRG_MODE_ACCESS 3'h5
`define DRG_MODE_REFRESH 3'h0
// Synchroniser reset value: request line and zero-wait idle high
`define DRG_PIN_RST 4'h3
// Bit positions inside the synchronised pin vector
`define DRG_PIN_RFREQ 0
`define DRG_PIN_ZWAIT 1
`define DRG_PIN_CASV 2
`define DRG_PIN_ILV 3

`endif

// File: include/drg_pkg.sv
// Types shared by the DRAM glue top and its byte lane generator.
// Assumes drg_consts.svh sits in the same include directory.
package drg_pkg;

  // ----------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACC  = 4'h2,
    ST_TAIL = 4'h4,
    ST_REF  = 4'h8
  } drg_state_t;

  // ----------------------------------------------------------------
  // Signal groups
  // ----------------------------------------------------------------
  // Host processor bus, synchronous to clk_sys
  typedef struct packed {
    logic       cs_n;
    logic       as_n;
    logic       ds_n;
    logic       read;
    logic       bank_bit;
    logic [3:0] lane_sel;
  } drg_host_t;

  // Lines toward the DRAM controller
  typedef struct packed {
    logic row_strobe_request_n;
    logic refresh_command_n;
    logic mode_select_two;
    logic mode_select_one;
    logic mode_select_zero;
  } drg_dram_t;

  // Per-byte strobes toward the DRAM array
  typedef struct packed {
    logic [3:0] write_enable_n;
    logic [3:0] col_strobe_n;
  } drg_lane_t;

endpackage

// File: logic/drg_lane_gen.sv
// Byte lane write enables or byte column strobes for a 32-bit word.
// Assumes host signals are on clk_sys and active comes from the sequencer.
`timescale 1ns/100ps

module drg_lane_gen (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input drg_pkg::drg_host_t host,
  input wire logic active,
  input wire logic cas_mode,
  output drg_pkg::drg_lane_t lanes
);
  import drg_pkg::*;

  drg_lane_t lanes_reg;

  // ----------------------------------------------------------------
  // One flop pair per byte lane
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      // Data strobe qualifies both kinds; the other kind stays high
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          lanes_reg.write_enable_n[i] <= 1'b1;
          lanes_reg.col_strobe_n[i] <= 1'b1;
        end else if (clk_en) begin
          lanes_reg.write_enable_n[i] <= !(active && !host.ds_n &&
            !host.read && host.lane_sel[i] && !cas_mode);
          lanes_reg.col_strobe_n[i] <= !(active && !host.ds_n &&
            host.lane_sel[i] && cas_mode);
        end
      end
    end
  endgenerate

  assign lanes = lanes_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_we_lane;
    @(posedge clk_sys) disable iff (reset)
    (clk_en && active && !host.ds_n && !host.read && host.lane_sel[0]
      && !cas_mode) |=> !lanes.write_enable_n[0];
  endproperty
  a_we_lane: assert property (p_we_lane)
    else $error("write enable missing on lane 0");

  property p_cas_lane;
    @(posedge clk_sys) disable iff (reset)
    !lanes.col_strobe_n[0] |-> $past(cas_mode) && $past(active);
  endproperty
  a_cas_lane: assert property (p_cas_lane)
    else $error("column strobe outside column-strobe access");

endmodule

// File: dv/drg_ctl_model.sv
// Behavioural stand-in for the DRAM controller's refresh request side.
// Assumes the glue's controller lines and clk_sys from the bench.
`timescale 1ns/100ps

module drg_ctl_model (
  input wire logic clk_sys,
  input wire logic reset,
  input drg_pkg::drg_dram_t dram_ctl,
  input wire logic req_go,
  input wire logic [1:0] clear_lag,
  output logic refresh_request_line
);
  import drg_pkg::*;

  logic seen_reg;
  logic [1:0] lag_reg;

  // ------------------------------------------------------------
  // Refresh request: raised on command, cleared by a mode 0 refresh
  // ------------------------------------------------------------
  // A nonzero lag models a slow controller; too slow would re-request
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      refresh_request_line <= 1'h1;
      seen_reg <= 1'h0;
      lag_reg <= 2'h0;
    end else begin
      if (req_go) begin
        refresh_request_line <= 1'h0;
      end
      if (!refresh_request_line && !seen_reg
          && dram_ctl.refresh_command_n === 1'h0
          && {dram_ctl.mode_select_two, dram_ctl.mode_select_one,
              dram_ctl.mode_select_zero} === 3'h0) begin
        seen_reg <= 1'h1;
        lag_reg <= clear_lag;
      end
      if (seen_reg) begin
        if (lag_reg == 2'h0) begin
          refresh_request_line <= 1'h1;
          seen_reg <= 1'h0;
        end else begin
          lag_reg <= lag_reg - 2'h1;
        end
      end
    end
  end
endmodule

// File: dv/tb.sv
// Self-checking bench for the DRAM access and refresh glue.
// Assumes drg_glue with its package; host driven on rising clk_sys.
`timescale 1ns/100ps

module tb;
  import drg_pkg::*;

  logic clk_sys, reset, req_go, zero_wait_select, lane_mode_cas;
  logic interleave_en, refresh_request_line, data_ack_n;
  logic previous_bank_flag;
  logic [1:0] clear_lag;
  drg_host_t host;
  drg_dram_t dram_ctl;
  drg_lane_t lanes;
  int fail_count, n_compared;
  localparam drg_host_t HOST_IDLE = '{cs_n: 1'h1, as_n: 1'h1, ds_n: 1'h1,
    read: 1'h1, bank_bit: 1'h0, lane_sel: 4'h0};

  // ------------------------------------------------------------
  // Design, controller model, clock
  // ------------------------------------------------------------
  drg_glue dut_u (.clk_sys(clk_sys), .reset(reset), .clk_en(1'h1),
    .host(host), .refresh_request_line(refresh_request_line),
    .zero_wait_select(zero_wait_select), .lane_mode_cas(lane_mode_cas),
    .interleave_en(interleave_en), .dram_ctl(dram_ctl), .lanes(lanes),
    .data_ack_n(data_ack_n), .previous_bank_flag(previous_bank_flag));
  drg_ctl_model ctl_u (.clk_sys(clk_sys), .reset(reset),
    .dram_ctl(dram_ctl), .req_go(req_go), .clear_lag(clear_lag),
    .refresh_request_line(refresh_request_line));

  // 125 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic print_verdict;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // 0 row strobe, 1 acknowledge, 2 refresh command
  function automatic logic pick(input int which);
    case (which)
      0: pick = dram_ctl.row_strobe_request_n;
      1: pick = data_ack_n;
      default: pick = dram_ctl.refresh_command_n;
    endcase
  endfunction

  // Bounded wait: falling edges until the line shows lvl
  task automatic wait_lvl(input int which, input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pick(which) !== lvl && n < 30);
  endtask

  task automatic start_acc(input logic bank, input logic rd,
                           input logic [3:0] ls);
    @(posedge clk_sys);
    host <= '{cs_n: 1'h0, as_n: 1'h0, ds_n: 1'h0, read: rd,
              bank_bit: bank, lane_sel: ls};
  endtask

  task automatic end_acc;
    @(posedge clk_sys);
    host <= HOST_IDLE;
  endtask

  task automatic pulse_req;
    @(posedge clk_sys);
    req_go <= 1'h1;
    @(posedge clk_sys);
    req_go <= 1'h0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    check("row", 8'(pick(0)), 8'h1);
    check("ack", 8'(pick(1)), 8'h1);
    check("refresh", 8'(pick(2)), 8'h1);
    check("mode", 8'({dram_ctl.mode_select_two, dram_ctl.mode_select_one,
      dram_ctl.mode_select_zero}), 8'h5);
    check("lanes", 8'(lanes), 8'hFF);
    check("prev bank", 8'(previous_bank_flag), 8'h0);
  endtask

  // Strobe without chip select must not start a cycle
  task automatic t_no_cs;
    @(posedge clk_sys);
    host <= '{cs_n: 1'h1, as_n: 1'h0, ds_n: 1'h0, read: 1'h1,
              bank_bit: 1'h0, lane_sel: 4'hF};
    repeat (6) begin
      @(negedge clk_sys);
      check("row no cs", 8'(pick(0) & pick(1)), 8'h1);
    end
    end_acc;
    repeat (3) @(negedge clk_sys);
  endtask

  // Writes may trail the column strobe; data in and out kept apart
  task automatic t_we(input logic rd, input logic [3:0] exp_we,
                      input logic ack_now);
    int n;
    start_acc(1'h0, rd, 4'h5);
    wait_lvl(0, 1'h0, n);
    check("row delay", 8'(n), 8'h2);
    check("mode acc", 8'({dram_ctl.mode_select_two,
      dram_ctl.mode_select_one, dram_ctl.mode_select_zero}), 8'h5);
    check("ack at row", 8'(pick(1)), 8'(ack_now));
    wait_lvl(1, 1'h0, n);
    check("ack delay", 8'(n), 8'h1);
    @(negedge clk_sys);
    check("write en", 8'(lanes.write_enable_n), 8'(exp_we));
    end_acc;
    repeat (2) @(negedge clk_sys);
    check("row/ack end", 8'({pick(0), pick(1)}), 8'h3);
    @(negedge clk_sys);
    check("we end", 8'(lanes.write_enable_n), 8'hF);
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic t_refresh(input int exp_len);
    int n;
    int again;
    again = 0;
    pulse_req;
    wait_lvl(2, 1'h0, n);
    check("ref start", 8'(pick(2)), 8'h0);
    check("ref mode/row", 8'({dram_ctl.mode_select_two,
      dram_ctl.mode_select_one, dram_ctl.mode_select_zero,
      pick(0)}), 8'h0);
    wait_lvl(2, 1'h1, n);
    check("ref length", 8'(n), 8'(exp_len));
    check("mode rest", 8'({dram_ctl.mode_select_two,
      dram_ctl.mode_select_one, dram_ctl.mode_select_zero}), 8'h5);
    repeat (12) begin
      @(negedge clk_sys);
      if (pick(2) === 1'h0) again = 1;
    end
    check("ref repeat", 8'(again), 8'h0);
  endtask

  // Refresh must wait for a running access, never hidden inside it
  task automatic t_ref_during_acc;
    int n;
    int hit;
    hit = 0;
    start_acc(1'h1, 1'h1, 4'h0);
    wait_lvl(0, 1'h0, n);
    pulse_req;
    repeat (8) begin
      @(negedge clk_sys);
      if (pick(2) === 1'h0) hit = 1;
    end
    check("hidden ref", 8'(hit), 8'h0);
    end_acc;
    wait_lvl(2, 1'h0, n);
    check("ref after acc", 8'(n <= 8), 8'h1);
    wait_lvl(2, 1'h1, n);
    repeat (4) @(negedge clk_sys);
  endtask

  // Access asked during refresh waits for refresh and precharge
  task automatic t_acc_during_ref;
    int n;
    pulse_req;
    wait_lvl(2, 1'h0, n);
    start_acc(1'h0, 1'h1, 4'h0);
    wait_lvl(2, 1'h1, n);
    check("ack in ref", 8'(pick(1)), 8'h1);
    wait_lvl(0, 1'h0, n);
    check("ref precharge", 8'(n >= 2), 8'h1);
    check("ack wait", 8'(pick(1)), 8'h1);
    wait_lvl(1, 1'h0, n);
    check("pending acc", 8'(n), 8'h1);
    end_acc;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic gap_run(input logic b2, output int gap);
    int n;
    start_acc(1'h0, 1'h1, 4'h0);
    wait_lvl(1, 1'h0, n);
    end_acc;
    start_acc(b2, 1'h1, 4'h0);
    wait_lvl(0, 1'h1, n);
    wait_lvl(0, 1'h0, gap);
    wait_lvl(1, 1'h0, n);
    end_acc;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic t_bank;
    int g_same;
    int g_diff;
    int g_off;
    gap_run(1'h0, g_same);
    check("same bank gap", 8'(g_same >= 2 && g_same <= 4), 8'h1);
    gap_run(1'h1, g_diff);
    check("other bank", 8'(g_diff < g_same), 8'h1);
    check("prev bank", 8'(previous_bank_flag), 8'h1);
    // Interleave off: another bank gets no shortcut
    @(posedge clk_sys);
    interleave_en <= 1'h0;
    repeat (3) @(negedge clk_sys);
    gap_run(1'h1, g_off);
    check("no interleave", 8'(g_off), 8'(g_same));
    @(posedge clk_sys);
    interleave_en <= 1'h1;
    repeat (3) @(negedge clk_sys);
  endtask

  // Column variant: byte strobes, row request ended after 2 cycles
  task automatic t_cas;
    int n;
    @(posedge clk_sys);
    lane_mode_cas <= 1'h1;
    repeat (4) @(negedge clk_sys);
    start_acc(1'h0, 1'h1, 4'h3);
    wait_lvl(0, 1'h0, n);
    wait_lvl(0, 1'h1, n);
    check("early end", 8'(n), 8'h2);
    check("ack held", 8'(pick(1)), 8'h0);
    check("col strobes", 8'(lanes.col_strobe_n), 8'hC);
    end_acc;
    repeat (3) @(negedge clk_sys);
    check("cas end", 8'({lanes.col_strobe_n, 3'h0, pick(1)}), 8'hF1);
    @(posedge clk_sys);
    lane_mode_cas <= 1'h0;
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    host = HOST_IDLE;
    reset = 1'h1;
    req_go = 1'h0;
    zero_wait_select = 1'h1;
    lane_mode_cas = 1'h0;
    interleave_en = 1'h1;
    clear_lag = 2'h0;
    fail_count = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'h0;
    @(negedge clk_sys);
    t_reset;
    repeat (4) @(negedge clk_sys);
    t_no_cs;
    t_we(1'h0, 4'hA, 1'h1);
    t_we(1'h1, 4'hF, 1'h1);
    t_refresh(3);
    clear_lag <= 2'h1;
    t_refresh(3);
    clear_lag <= 2'h0;
    t_ref_during_acc;
    t_acc_during_ref;
    t_bank;
    @(posedge clk_sys);
    zero_wait_select <= 1'h0;
    repeat (4) @(negedge clk_sys);
    t_we(1'h0, 4'hA, 1'h0);
    t_refresh(2);
    @(posedge clk_sys);
    zero_wait_select <= 1'h1;
    t_cas;
    print_verdict;
  end

  // Whole run is a few hundred cycles; this is about twenty times that
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    print_verdict;
  end
endmodule
